// ---- design/intc_regs.vh ----
/*
  Register map, field positions, reset values and response codes of the
  interrupt flag, mask and non-maskable source block.
  Assumes a 32-bit AXI4-Lite register bus with word-aligned byte addresses.
*/
`ifndef INTC_REGS_VH
`define INTC_REGS_VH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define OFS_NMI_SOURCE_FLAGS 4'h0
`define OFS_PENDING_FLAGS 4'h4
`define OFS_MASK_BITS 4'h8
`define OFS_EVENT_STATUS 4'hC
`define ADDR_WIDTH 4
`define OFS_EVENT_MASK_HI 1'b1

// ----------------------------------------------------------------------
// Non-maskable source bit positions
// ----------------------------------------------------------------------
`define NMI_BIT_WATCHDOG 0
`define NMI_BIT_VOLTAGE_DROP 2
`define NMI_BIT_VOLTAGE_RECOVERY 3
`define NMI_FIELD_WIDTH 4
`define NMI_USED_BITS 4'hD

// ----------------------------------------------------------------------
// Request source positions in flag and mask registers
// ----------------------------------------------------------------------
`define SRC_RECEIVE0 0
`define SRC_RECEIVE1 1
`define SRC_TRANSMIT0 2
`define SRC_TRANSMIT1 3
`define SRC_RECEIVE2 4
`define SRC_RECEIVE3 5
`define SRC_RECEIVE5 6
`define SRC_TRANSMIT2 7
`define SRC_TRANSMIT3 8
`define SRC_TRANSMIT5 9
`define NUM_ASSIGNED_SOURCES 10

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define RST_NMI_SOURCE_FLAGS 32'h00000000
`define RST_PENDING_FLAGS 32'h00000000
`define RST_MASK_BITS 32'h00000000
`define RST_EVENT_STATUS 4'h0
`define RST_EVENT_MASK 4'h0

// ----------------------------------------------------------------------
// AXI response codes
// ----------------------------------------------------------------------
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// ---- design/rise_detect.v ----
/*
  Rising-edge detector for a vector of same-clock levels.
  Assumes inputs are already in the aclk domain; no synchroniser here.
*/
module rise_detect #(
  parameter WIDTH = 1
) (
  // Clock and reset
  input wire aclk,
  input wire aresetn,
  // Levels in, one-cycle pulses out
  input wire [WIDTH-1:0] level,
  output wire [WIDTH-1:0] rise
);

  reg [WIDTH-1:0] level_d;

  always @(posedge aclk) begin
    if (!aresetn) begin
      level_d <= {WIDTH{1'b0}};
    end else begin
      level_d <= level;
    end
  end

  assign rise = level & ~level_d;

endmodule

// ---- design/sticky_flags.v ----
/*
  Vector of sticky flags: set pulses and clear pulses per bit.
  Assumes a set and a clear in the same cycle must keep the flag set.
*/
module sticky_flags #(
  parameter WIDTH = 1
) (
  // Clock and reset
  input wire aclk,
  input wire aresetn,
  // Per-bit set and clear
  input wire [WIDTH-1:0] set,
  input wire [WIDTH-1:0] clear,
  output reg [WIDTH-1:0] flags
);

  // Set wins so a coincident event is never lost
  always @(posedge aclk) begin
    if (!aresetn) begin
      flags <= {WIDTH{1'b0}};
    end else begin
      flags <= set | (flags & ~clear);
    end
  end

endmodule

// ---- design/interrupt_flag_mask_nmi_status.v ----
/*
  Interrupt flag and mask logic with a non-maskable source record,
  reached over an AXI4-Lite slave port.
  Assumes request and non-maskable source lines come from logic on aclk,
  and that the master keeps at most one read and one write in flight.
*/
// Overview of operation
// - Set bit 3 on voltage recovery event
// - Set bit 2 on supply drop event
// - Set bit 0 on watchdog event
// - Source register read-only, unused bits zero
// - Source positions zero to nine, rest unassigned
// - Flag reads one while request pending
// - Write zero clears flag, one ignored
// - Mask bit one blocks, zero allows
`include "intc_regs.vh"

module interrupt_flag_mask_nmi_status #(
  parameter NUM_SOURCES = `NUM_ASSIGNED_SOURCES
) (
  // Clock and reset
  input wire aclk,
  input wire aresetn,
  // AXI4-Lite write address
  input wire [`ADDR_WIDTH-1:0] awaddr,
  input wire [2:0] awprot,
  input wire awvalid,
  output reg awready,
  // AXI4-Lite write data
  input wire [31:0] wdata,
  input wire [3:0] wstrb,
  input wire wvalid,
  output reg wready,
  // AXI4-Lite write response
  output reg [1:0] bresp,
  output reg bvalid,
  input wire bready,
  // AXI4-Lite read address
  input wire [`ADDR_WIDTH-1:0] araddr,
  input wire [2:0] arprot,
  input wire arvalid,
  output reg arready,
  // AXI4-Lite read data
  output reg [31:0] rdata,
  output reg [1:0] rresp,
  output reg rvalid,
  input wire rready,
  // Peripheral request levels
  input wire [NUM_SOURCES-1:0] request_lines,
  // Non-maskable source levels
  input wire watchdog_timer_nmi,
  input wire low_voltage_detector_drop,
  input wire low_voltage_detector_recovery,
  // Towards the processor core
  output reg [31:0] core_requests,
  output reg core_nmi,
  // Summary interrupt from event status
  output reg irq
);

  // --------------------------------------------------------------------
  // Declarations
  // --------------------------------------------------------------------
  reg [`ADDR_WIDTH-1:0] aw_addr_q;
  reg aw_held;
  reg [31:0] w_data_q;
  reg [3:0] w_strb_q;
  reg w_held;
  reg next_aw_held;
  reg next_w_held;
  reg next_bvalid;
  reg next_rvalid;
  reg [31:0] read_value;
  reg read_hit;
  reg write_hit;
  reg [31:0] mask_bits;
  reg [`NMI_FIELD_WIDTH-1:0] event_mask;
  reg [31:0] strb_bits;
  reg [31:0] pending_clear;
  reg [`NMI_FIELD_WIDTH-1:0] event_clear;
  reg [`NMI_FIELD_WIDTH-1:0] nmi_clear;
  wire aw_take;
  wire w_take;
  wire ar_take;
  wire [`ADDR_WIDTH-1:0] ar_word;
  wire do_write;
  wire [NUM_SOURCES-1:0] request_rise;
  wire [2:0] nmi_levels;
  wire [2:0] nmi_rise;
  wire [31:0] pending_set;
  wire [31:0] pending_flags;
  wire [`NMI_FIELD_WIDTH-1:0] nmi_set;
  wire [`NMI_FIELD_WIDTH-1:0] nmi_flags;
  wire [`NMI_FIELD_WIDTH-1:0] event_flags;

  assign aw_take = awvalid & awready;
  assign w_take = wvalid & wready;
  assign ar_take = arvalid & arready;
  // Byte lanes dropped once, so decode and read-to-clear agree
  assign ar_word = {araddr[`ADDR_WIDTH-1:2], 2'b00};
  // Write fires only from latched halves, so address and data may
  // arrive in either order
  assign do_write = aw_held & w_held & ~bvalid;

  // --------------------------------------------------------------------
  // Source edge detection
  // --------------------------------------------------------------------
  // Edges, not levels, set flags; a held line cannot re-set a flag
  // that software just cleared
  rise_detect #(
    .WIDTH(NUM_SOURCES)
  ) u_request_rise (
    .aclk(aclk),
    .aresetn(aresetn),
    .level(request_lines),
    .rise(request_rise)
  );

  assign nmi_levels = {low_voltage_detector_recovery, low_voltage_detector_drop,
                       watchdog_timer_nmi};

  rise_detect #(
    .WIDTH(3)
  ) u_nmi_rise (
    .aclk(aclk),
    .aresetn(aresetn),
    .level(nmi_levels),
    .rise(nmi_rise)
  );

  // --------------------------------------------------------------------
  // Pending request flags
  // --------------------------------------------------------------------
  // Unassigned positions never set
  // Wider builds map straight through
  generate
    if (NUM_SOURCES < 32) begin : g_pad
      assign pending_set = {{(32 - NUM_SOURCES){1'b0}}, request_rise};
    end else begin : g_full
      assign pending_set = request_rise[31:0];
    end
  endgenerate

  always @(*) begin
    strb_bits = {{8{w_strb_q[3]}}, {8{w_strb_q[2]}}, {8{w_strb_q[1]}}, {8{w_strb_q[0]}}};
    pending_clear = 32'h00000000;
    if (do_write && (aw_addr_q == `OFS_PENDING_FLAGS)) begin
      pending_clear = strb_bits & ~w_data_q;
    end
  end

  sticky_flags #(
    .WIDTH(32)
  ) u_pending (
    .aclk(aclk),
    .aresetn(aresetn),
    .set(pending_set),
    .clear(pending_clear),
    .flags(pending_flags)
  );

  // --------------------------------------------------------------------
  // Non-maskable source record
  // --------------------------------------------------------------------
  assign nmi_set[`NMI_BIT_WATCHDOG] = nmi_rise[0];
  assign nmi_set[1] = 1'b0;
  assign nmi_set[`NMI_BIT_VOLTAGE_DROP] = nmi_rise[1];
  assign nmi_set[`NMI_BIT_VOLTAGE_RECOVERY] = nmi_rise[2];

  // Record clears on the read that reports it; bus writes never touch it
  always @(*) begin
    nmi_clear = {`NMI_FIELD_WIDTH{1'b0}};
    if (ar_take && (ar_word == `OFS_NMI_SOURCE_FLAGS)) begin
      nmi_clear = `NMI_USED_BITS;
    end
  end

  sticky_flags #(
    .WIDTH(`NMI_FIELD_WIDTH)
  ) u_nmi_record (
    .aclk(aclk),
    .aresetn(aresetn),
    .set(nmi_set),
    .clear(nmi_clear),
    .flags(nmi_flags)
  );

  // --------------------------------------------------------------------
  // Event status for the summary interrupt
  // --------------------------------------------------------------------
  // Own copy of the source events, so a read of the record leaves the
  // summary interrupt up until software clears it here
  // Lane 0 is write-one-to-clear status, lane 1 the mask
  always @(*) begin
    event_clear = {`NMI_FIELD_WIDTH{1'b0}};
    if (do_write && (aw_addr_q == `OFS_EVENT_STATUS) && w_strb_q[0]) begin
      event_clear = w_data_q[`NMI_FIELD_WIDTH-1:0] & `NMI_USED_BITS;
    end
  end

  sticky_flags #(
    .WIDTH(`NMI_FIELD_WIDTH)
  ) u_event_status (
    .aclk(aclk),
    .aresetn(aresetn),
    .set(nmi_set),
    .clear(event_clear),
    .flags(event_flags)
  );

  // --------------------------------------------------------------------
  // Mask registers
  // --------------------------------------------------------------------
  // Byte lanes honoured so a narrow write leaves the other lanes alone
  always @(posedge aclk) begin
    if (!aresetn) begin
      mask_bits <= `RST_MASK_BITS;
      event_mask <= `RST_EVENT_MASK;
    end else if (do_write) begin
      if (aw_addr_q == `OFS_MASK_BITS) begin
        mask_bits <= (mask_bits & ~strb_bits) | (w_data_q & strb_bits);
      end
      if ((aw_addr_q == `OFS_EVENT_STATUS) && w_strb_q[1]) begin
        event_mask <= w_data_q[8 +: `NMI_FIELD_WIDTH] & `NMI_USED_BITS;
      end
    end
  end

  // --------------------------------------------------------------------
  // Outputs towards the core
  // --------------------------------------------------------------------
  // Registered, so every output leaves a flop; costs one cycle
  always @(posedge aclk) begin
    if (!aresetn) begin
      core_requests <= 32'h00000000;
      core_nmi <= 1'b0;
      irq <= 1'b0;
    end else begin
      core_requests <= pending_flags & ~mask_bits;
      core_nmi <= |nmi_rise;
      irq <= |(event_flags & ~event_mask);
    end
  end

  // --------------------------------------------------------------------
  // Write channel handshakes
  // --------------------------------------------------------------------
  always @(*) begin
    next_aw_held = (aw_held | aw_take) & ~do_write;
    next_w_held = (w_held | w_take) & ~do_write;
    next_bvalid = (bvalid & ~bready) | do_write;
  end

  // Only the writable registers answer OKAY
  always @(*) begin
    write_hit = (aw_addr_q == `OFS_PENDING_FLAGS) || (aw_addr_q == `OFS_MASK_BITS) ||
                (aw_addr_q == `OFS_EVENT_STATUS);
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr_q <= {`ADDR_WIDTH{1'b0}};
      w_data_q <= 32'h00000000;
      w_strb_q <= 4'h0;
      awready <= 1'b0;
      wready <= 1'b0;
      bvalid <= 1'b0;
      bresp <= `RESP_OKAY;
    end else begin
      aw_held <= next_aw_held;
      w_held <= next_w_held;
      if (aw_take) begin
        aw_addr_q <= {awaddr[`ADDR_WIDTH-1:2], 2'b00};
      end
      if (w_take) begin
        w_data_q <= wdata;
        w_strb_q <= wstrb;
      end
      // Ready only while the holding slot is empty and no response waits
      awready <= ~next_aw_held & ~next_bvalid;
      wready <= ~next_w_held & ~next_bvalid;
      bvalid <= next_bvalid;
      if (do_write) begin
        // Source record is read-only: a write there answers with an error
        bresp <= write_hit ? `RESP_OKAY : `RESP_SLVERR;
      end
    end
  end

  // --------------------------------------------------------------------
  // Read channel
  // --------------------------------------------------------------------
  // Decoded from the live address and captured at the take edge
  always @(*) begin
    read_value = 32'h00000000;
    read_hit = 1'b1;
    case (ar_word)
      `OFS_NMI_SOURCE_FLAGS: begin
        read_value = {28'h0000000, nmi_flags & `NMI_USED_BITS};
      end
      `OFS_PENDING_FLAGS: begin
        read_value = pending_flags;
      end
      `OFS_MASK_BITS: begin
        read_value = mask_bits;
      end
      `OFS_EVENT_STATUS: begin
        read_value = {20'h00000, event_mask, 4'h0, event_flags};
      end
      default: begin
        read_hit = 1'b0;
      end
    endcase
  end

  // Data stands until the master takes it
  always @(*) begin
    next_rvalid = (rvalid & ~rready) | ar_take;
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= 32'h00000000;
      rresp <= `RESP_OKAY;
    end else begin
      // One read in flight; the next address waits for the data handshake
      arready <= ~next_rvalid & ~ar_take;
      rvalid <= next_rvalid;
      if (ar_take) begin
        rdata <= read_value;
        rresp <= read_hit ? `RESP_OKAY : `RESP_SLVERR;
      end
    end
  end

endmodule

// ---- testbench/intc_monitor.sv ----
/*
  Port-level checker for the interrupt flag and mask block.
  Assumes it is bound into the block's top module; one clock domain.
*/
module intc_monitor (
  // Clock and reset
  input wire aclk,
  input wire aresetn,
  // Bus handshakes
  input wire wvalid,
  input wire wready,
  input wire bvalid,
  input wire bready,
  input wire [1:0] bresp,
  input wire arvalid,
  input wire arready,
  input wire rvalid,
  input wire rready,
  input wire [31:0] rdata,
  // Sources and core side
  input wire watchdog_timer_nmi,
  input wire low_voltage_detector_drop,
  input wire low_voltage_detector_recovery,
  input wire [31:0] core_requests,
  input wire core_nmi,
  input wire irq
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----
  // Edge helper
  // ----
  reg [2:0] src_d;
  wire [2:0] src = {low_voltage_detector_recovery, low_voltage_detector_drop, watchdog_timer_nmi};
  wire [2:0] src_rise = src & ~src_d;

  always @(posedge aclk) begin
    src_d <= aresetn ? src : 3'h0;
  end

  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_nmi_pulse: assert property (|src_rise |=> core_nmi)
    else $error("nmi pulse missing");
  a_nmi_cause: assert property (core_nmi |-> $past(|src_rise))
    else $error("nmi pulse without source edge");
  a_nmi_single: assert property (core_nmi && !(|src_rise) |=> !core_nmi)
    else $error("nmi pulse too long");
  a_upper_quiet: assert property (core_requests[31:10] == 22'h0)
    else $error("unassigned request forwarded");
  a_reset_clear: assert property ($rose(aresetn) |-> core_requests == 32'h0 && !irq)
    else $error("outputs not clear after reset");
  a_bresp_once: assert property (bvalid && bready |=> !bvalid)
    else $error("write response repeated");
  a_rdata_once: assert property (rvalid && rready |=> !rvalid)
    else $error("read answer repeated");
  a_read_reply: assert property (arvalid && arready |=> rvalid)
    else $error("read answer late");
  a_write_reply: assert property (wvalid && wready |-> ##[1:3] bvalid)
    else $error("write answer late");

  cover property (core_nmi);
  cover property (irq);
  cover property (|core_requests);
endmodule

// ---- testbench/request_sources.sv ----
/*
  Peripheral and non-maskable request sources on the block's far side.
  Assumes the bench asks for one-cycle level pulses through fire.
*/
module request_sources (
  input wire aclk,
  input wire aresetn,
  input wire [12:0] fire,
  output reg [9:0] request_lines = 10'h0,
  output reg watchdog_timer_nmi = 1'h0,
  output reg low_voltage_detector_drop = 1'h0,
  output reg low_voltage_detector_recovery = 1'h0
);
  timeunit 1ns;
  timeprecision 1ns;
  // Levels stay high one cycle, so each fire is one rising edge
  always @(posedge aclk) begin
    {low_voltage_detector_recovery, low_voltage_detector_drop, watchdog_timer_nmi,
     request_lines} <= aresetn ? fire : 13'h0;
  end
endmodule

// ---- testbench/interrupt_flag_mask_nmi_status_tb.sv ----
/*
  Self-checking bench for the interrupt flag, mask and nmi record block.
  Assumes the register header is on the include path.
*/
`include "intc_regs.vh"
module interrupt_flag_mask_nmi_status_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic aclk = 1'h0, aresetn = 1'h0;
  logic [3:0] awaddr = 4'h0, araddr = 4'h0, wstrb = 4'hF;
  logic [2:0] awprot = 3'h0, arprot = 3'h0;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic [31:0] wdata = 32'h0, seed = 32'h0DE8, pend, msk, got;
  logic [12:0] fire = 13'h0;
  logic [1:0] resp;
  wire awready, wready, bvalid, arready, rvalid, core_nmi, irq, watchdog_timer_nmi, drop, recov;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata, core_requests;
  wire [9:0] request_lines;
  int n_fail = 0, compares = 0;

  always #25 aclk = ~aclk;

  interrupt_flag_mask_nmi_status dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
    .awprot(awprot), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arprot(arprot), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready), .request_lines(request_lines),
    .watchdog_timer_nmi(watchdog_timer_nmi), .low_voltage_detector_drop(drop),
    .low_voltage_detector_recovery(recov), .core_requests(core_requests),
    .core_nmi(core_nmi), .irq(irq));

  request_sources src (.aclk(aclk), .aresetn(aresetn), .fire(fire),
    .request_lines(request_lines), .watchdog_timer_nmi(watchdog_timer_nmi),
    .low_voltage_detector_drop(drop), .low_voltage_detector_recovery(recov));

  // ----
  // Helpers
  // ----
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction

  function automatic logic [31:0] fwd(input logic [31:0] p, input logic [31:0] m);
    return p & ~m;
  endfunction

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Answer ready from the start; each half released at the edge it is taken
  task automatic wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
    bit done;
    done = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    while (!done) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'h0;
      if (wvalid && wready) wvalid <= 1'h0;
      if (bvalid) begin
        r = bresp;
        bready <= 1'h0;
        done = 1;
      end
    end
  endtask

  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    bit done;
    done = 0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    while (!done) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'h0;
      if (rvalid) begin
        d = rdata;
        rready <= 1'h0;
        done = 1;
      end
    end
  endtask

  task automatic pulse(input logic [12:0] f);
    @(posedge aclk);
    fire <= f;
    @(posedge aclk);
    fire <= 13'h0;
    repeat (5) @(posedge aclk);
  endtask

  task automatic close_out;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // ----
  // Tests
  // ----
  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'h1;
    repeat (2) @(posedge aclk);
    for (int i = 0; i < 3; i++) begin
      rd(4'(i * 4), got);
      chk("reset value", got, 32'h0);
    end
    wr(`OFS_NMI_SOURCE_FLAGS, 32'hFFFFFFFF, resp);
    chk("ro write resp", {30'h0, resp}, {30'h0, `RESP_SLVERR});
    $display("reset test done");
    pend = 32'h0;
    for (int n = 0; n < 10; n++) begin
      pulse(13'h1 << n);
      pend[n] = 1'h1;
      rd(`OFS_PENDING_FLAGS, got);
      chk("pending", got, pend);
      chk("core map", core_requests, pend);
    end
    seed = xs(seed);
    wr(`OFS_PENDING_FLAGS, seed, resp);
    pend = pend & seed;
    rd(`OFS_PENDING_FLAGS, got);
    chk("clear by zero", got, pend);
    seed = xs(seed);
    msk = seed;
    wr(`OFS_MASK_BITS, msk, resp);
    rd(`OFS_MASK_BITS, got);
    chk("mask", got, msk);
    seed = xs(seed);
    wstrb <= 4'h3;
    wr(`OFS_MASK_BITS, seed, resp);
    wstrb <= 4'hF;
    msk = {msk[31:16], seed[15:0]};
    rd(`OFS_MASK_BITS, got);
    chk("mask lanes", got, msk);
    pulse(13'h3FF);
    pend = pend | 32'h3FF;
    rd(`OFS_PENDING_FLAGS, got);
    chk("masked persist", got, pend);
    chk("core masked", core_requests, fwd(pend, msk));
    wr(`OFS_MASK_BITS, 32'h0, resp);
    repeat (2) @(posedge aclk);
    chk("core unmasked", core_requests, pend);
    wr(`OFS_PENDING_FLAGS, 32'h0, resp);
    rd(`OFS_PENDING_FLAGS, got);
    chk("clear all", got, 32'h0);
    $display("flag test done");
    for (int i = 0; i < 3; i++) begin
      pulse(13'h400 << i);
      rd(`OFS_NMI_SOURCE_FLAGS, got);
      chk("nmi source", got, 32'h1 << (i == 0 ? 0 : i + 1));
      rd(`OFS_NMI_SOURCE_FLAGS, got);
      chk("nmi cleared", got, 32'h0);
    end
    $display("nmi test done");
    chk("irq set", {31'h0, irq}, 32'h1);
    wr(`OFS_EVENT_STATUS, 32'h00000D00, resp);
    repeat (2) @(posedge aclk);
    chk("irq masked", {31'h0, irq}, 32'h0);
    wr(`OFS_EVENT_STATUS, 32'h0000000D, resp);
    rd(`OFS_EVENT_STATUS, got);
    chk("event clear", got, 32'h0);
    pulse(13'h400);
    chk("irq again", {31'h0, irq}, 32'h1);
    $display("irq test done");
    pulse(13'h3FF);
    wr(`OFS_MASK_BITS, 32'h5, resp);
    repeat (2) @(posedge aclk);
    chk("core before reset", core_requests, fwd(32'h3FF, 32'h5));
    aresetn <= 1'h0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'h1;
    repeat (2) @(posedge aclk);
    chk("core after reset", core_requests, 32'h0);
    chk("irq after reset", {31'h0, irq}, 32'h0);
    for (int i = 0; i < 4; i++) begin
      rd(4'(i * 4), got);
      chk("rerun reset value", got, 32'h0);
    end
    $display("mid-run reset test done");
    close_out;
  end

  initial begin
    repeat (20000) @(posedge aclk);
    n_fail++;
    close_out;
  end
endmodule

bind interrupt_flag_mask_nmi_status intc_monitor mon (.aclk(aclk), .aresetn(aresetn),
  .wvalid(wvalid), .wready(wready), .bvalid(bvalid), .bready(bready), .bresp(bresp),
  .arvalid(arvalid), .arready(arready), .rvalid(rvalid), .rready(rready), .rdata(rdata),
  .watchdog_timer_nmi(watchdog_timer_nmi),
  .low_voltage_detector_drop(low_voltage_detector_drop),
  .low_voltage_detector_recovery(low_voltage_detector_recovery),
  .core_requests(core_requests), .core_nmi(core_nmi), .irq(irq));
